// [rtl/dac_pkg.sv]
// constants, carriers and the register map of the two-channel converter control block
package dac_pkg;

  // ----------------------------------------------------------------
  // register byte addresses on the cpu memory bus
  // ----------------------------------------------------------------
  localparam logic [19:0] ADDR_PORT_ANALOG_DIGITAL_SELECT = 20'hF0076;
  localparam logic [19:0] ADDR_PERIPHERAL_CLOCK_ENABLE_ONE = 20'hF007A;
  localparam logic [19:0] ADDR_PORT_TWO_DIRECTION = 20'hFFF22;
  localparam logic [19:0] ADDR_PORT_TWO_DATA = 20'hFFF02;
  localparam logic [19:0] ADDR_CHANNEL0_OUTPUT_VALUE = 20'hFFF58;
  localparam logic [19:0] ADDR_CHANNEL1_OUTPUT_VALUE = 20'hFFF5A;
  localparam logic [19:0] ADDR_CONVERTER_MODE_CONTROL = 20'hFFF5C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CONVERTER_CLOCK_GATE_BIT = 7;
  localparam int CHANNEL0_ENABLE_BIT = 4;
  localparam int CHANNEL1_ENABLE_BIT = 5;
  localparam int CHANNEL0_MODE_BIT = 0;
  localparam int CHANNEL1_MODE_BIT = 1;
  localparam int CODE_WIDTH = 10;
  localparam int CHANNEL_COUNT = 2;
  localparam int FIRST_OUTPUT_PIN = 2;   // analog_out_zero on pin 2, one on pin 3
  localparam int CODE_FULL_SCALE = 1024; // output = ref * code / full scale

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_PORT_ANALOG_DIGITAL_SELECT = 8'h00;
  localparam logic [7:0] RESET_PORT_TWO_DIRECTION = 8'hFF;
  localparam logic [7:0] RESET_PORT_TWO_DATA = 8'h00;
  localparam logic [1:0] RESET_CHANNEL_BITS = 2'h0;
  localparam logic [9:0] RESET_CHANNEL_VALUE = 10'h000;

  // ----------------------------------------------------------------
  // timing: settling interval of the ladder
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 20;
  localparam int SETTLE_TIME_NS = 3000;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [19:0] addr;  // byte address
    logic wr;           // one-cycle write strobe
    logic rd;           // one-cycle read strobe
    logic [15:0] wdata; // byte registers use the low lane
  } dac_req_t;

  typedef struct packed {
    logic [7:0] out; // port data driven to the pins
    logic [7:0] oe;  // high while the digital buffer drives
  } dac_pins_t;

endpackage

// [rtl/dac_channel.sv]
// one converter channel: start decision, settling count and held output code
`timescale 1ns/1ns
module dac_channel
  import dac_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic enable,
  input wire logic rt_mode,
  input wire logic value_write,
  input wire logic trigger,
  input wire logic [9:0] value,
  output logic [9:0] code,
  output logic busy,
  output logic settled
);

  localparam int CW = $clog2(SETTLE + 1);
  localparam logic [CW-1:0] SETTLE_LOAD = CW'(SETTLE);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic was_enabled; // enable seen last cycle, for the rising edge
    logic [CW-1:0] count;
    logic [9:0] code;
    logic busy;
    logic settled;
  } dac_chan_state_t;

  dac_chan_state_t st;
  dac_chan_state_t next_st;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic start;
    start = 1'b0;
    next_st = st;
    next_st.was_enabled = enable;
    // enabling also starts, so a 1-0-1 sequence waits after the last 1
    if (enable && !st.was_enabled) begin
      start = 1'b1;
    end else if (enable && !rt_mode && value_write) begin
      start = 1'b1;
    end else if (enable && rt_mode && trigger) begin
      start = 1'b1;
    end
    if (clear || !enable) begin
      // stopping keeps the last code held on the ladder
      next_st.busy = 1'b0;
      next_st.settled = 1'b0;
      next_st.count = '0;
      if (clear) begin
        next_st.code = RESET_CHANNEL_VALUE;
      end
    end else if (start) begin
      // a new start aborts any settling in progress
      next_st.code = value;
      next_st.count = SETTLE_LOAD;
      next_st.busy = 1'b1;
      next_st.settled = 1'b0;
    end else if (st.busy) begin
      if (st.count == CW'(1)) begin
        next_st.busy = 1'b0;
        next_st.settled = 1'b1;
      end
      next_st.count = st.count - CW'(1);
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign code = st.code;
  assign busy = st.busy;
  assign settled = st.settled;

endmodule

// [rtl/dac_control.sv]
// register file, clock gate and shared pin control of the two-channel converter
`timescale 1ns/1ns
module dac_control
  import dac_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire dac_req_t cpu_req,
  output logic [15:0] cpu_rdata,
  input wire logic [7:0] pin_in,
  output dac_pins_t pins,
  input wire logic [7:0] adc_channel_select,
  input wire logic [1:0] rt_trigger,
  output logic [1:0] analog_drive,
  output logic [7:0] analog_input_pin,
  output logic [1:0] setting_conflict,
  output logic [19:0] channel_code,
  output logic [1:0] channel_busy,
  output logic [1:0] channel_settled
);

  // ----------------------------------------------------------------
  // state of the register file and pin control
  // ----------------------------------------------------------------
  // everything the bus can see or the pins show lives here, so one
  // always_ff registers it and every output comes straight from a flop;
  // the cost is a cycle of latency on adc_channel_select changes; register writes reach the pins on the edge that stores them
  typedef struct packed {
    logic gate;                           // converter clock gate
    logic [7:0] adsel;                    // analog/digital pin select
    logic [7:0] dir;                      // port two direction
    logic [7:0] data;                     // port two output latch
    logic [1:0] enable;                   // channel conversion enable
    logic [1:0] mode;                     // channel mode select
    logic [CHANNEL_COUNT-1:0][9:0] value; // channel output values
    logic [1:0] value_write;              // one-cycle write pulses
    logic [15:0] rdata;
    dac_pins_t pins;
    logic [1:0] drive;
    logic [7:0] ana_in;
    logic [1:0] conflict;
  } dac_state_t;

  dac_state_t st;
  dac_state_t next_st;

  // channel results, returned by the generated channels below
  logic [1:0] code_busy;
  logic [1:0] code_settled;
  logic [CHANNEL_COUNT-1:0][9:0] code;

  // ----------------------------------------------------------------
  // bus access, gating and pin matrix
  // ----------------------------------------------------------------
  // one process computes the whole next state; outputs follow an edge later
  always_comb begin
    logic [7:0] chan_mask;
    logic [7:0] port_read;
    chan_mask = 8'h00;
    port_read = 8'h00;
    // defaults: hold every register, no pulses, read data back to zero
    next_st = st;
    next_st.value_write = 2'h0;
    next_st.rdata = 16'h0000;

    // writes; converter registers only while the gate is on
    // port select, direction and data stay writable with the gate off,
    // so the pins can be parked before the converter is powered
    if (cpu_req.wr) begin
      unique case (cpu_req.addr)
        ADDR_PORT_ANALOG_DIGITAL_SELECT: next_st.adsel = cpu_req.wdata[7:0];
        ADDR_PERIPHERAL_CLOCK_ENABLE_ONE: begin
          // only the gate bit is stored; low bits read back zero
          next_st.gate = cpu_req.wdata[CONVERTER_CLOCK_GATE_BIT];
        end
        ADDR_PORT_TWO_DIRECTION: next_st.dir = cpu_req.wdata[7:0];
        ADDR_PORT_TWO_DATA: next_st.data = cpu_req.wdata[7:0];
        ADDR_CONVERTER_MODE_CONTROL: begin
          if (st.gate) begin
            next_st.enable = {cpu_req.wdata[CHANNEL1_ENABLE_BIT],
                              cpu_req.wdata[CHANNEL0_ENABLE_BIT]};
            next_st.mode = {cpu_req.wdata[CHANNEL1_MODE_BIT],
                            cpu_req.wdata[CHANNEL0_MODE_BIT]};
          end
        end
        ADDR_CHANNEL0_OUTPUT_VALUE: begin
          if (st.gate) begin
            next_st.value[0] = cpu_req.wdata[CODE_WIDTH-1:0];
            next_st.value_write[0] = 1'b1;
          end
        end
        ADDR_CHANNEL1_OUTPUT_VALUE: begin
          if (st.gate) begin
            next_st.value[1] = cpu_req.wdata[CODE_WIDTH-1:0];
            next_st.value_write[1] = 1'b1;
          end
        end
        default: ; // unmapped writes are dropped
      endcase
    end

    // gate off holds every converter register at reset
    // testing the next gate value clears them on the edge that stores
    // the gate, so reads give defaults from the very next cycle
    if (!next_st.gate) begin
      next_st.enable = RESET_CHANNEL_BITS;
      next_st.mode = RESET_CHANNEL_BITS;
      next_st.value = {CHANNEL_COUNT{RESET_CHANNEL_VALUE}};
      next_st.value_write = 2'h0;
    end

    // port read: analog input reads zero, analog output reads latch
    // pin_in is taken as already synchronous; there is no synchroniser,
    // so a pin from outside the clock domain must be retimed upstream
    for (int n = 0; n < 8; n++) begin
      if (!st.adsel[n] && st.dir[n]) begin
        port_read[n] = 1'b0;
      end else if (st.dir[n]) begin
        port_read[n] = pin_in[n];
      end else begin
        port_read[n] = st.data[n];
      end
    end

    // reads; registered, answered on the next edge
    // the read sees the registers before this edge, so a write and a read
    // of one register in the same cycle returns the old contents
    if (cpu_req.rd) begin
      unique case (cpu_req.addr)
        ADDR_PORT_ANALOG_DIGITAL_SELECT: next_st.rdata = {8'h00, st.adsel};
        ADDR_PERIPHERAL_CLOCK_ENABLE_ONE: next_st.rdata = {8'h00, st.gate, 7'h00};
        ADDR_PORT_TWO_DIRECTION: next_st.rdata = {8'h00, st.dir};
        ADDR_PORT_TWO_DATA: next_st.rdata = {8'h00, port_read};
        ADDR_CONVERTER_MODE_CONTROL: begin
          // cleared while gated off, so reads give defaults there too
          next_st.rdata = {8'h00, 2'h0, st.enable, 2'h0, st.mode};
        end
        ADDR_CHANNEL0_OUTPUT_VALUE: next_st.rdata = {6'h00, st.value[0]};
        ADDR_CHANNEL1_OUTPUT_VALUE: next_st.rdata = {6'h00, st.value[1]};
        default: next_st.rdata = 16'h0000; // unmapped reads zero
      endcase
    end

    // pin matrix, built from the settled register values
    // only the two shared pins carry a channel output
    for (int i = 0; i < CHANNEL_COUNT; i++) begin
      chan_mask[FIRST_OUTPUT_PIN + i] = next_st.enable[i];
    end
    for (int n = 0; n < 8; n++) begin
      // digital buffer only on digital pins in output direction
      next_st.pins.oe[n] = next_st.adsel[n] & ~next_st.dir[n];
      // a stopped analog pin in input direction is an analog input
      next_st.ana_in[n] = ~next_st.adsel[n] & next_st.dir[n] & ~chan_mask[n];
    end
    next_st.pins.out = next_st.data;
    for (int i = 0; i < CHANNEL_COUNT; i++) begin
      // drive only when the adc is not looking at this pin
      next_st.drive[i] = ~next_st.adsel[FIRST_OUTPUT_PIN + i]
                         & next_st.dir[FIRST_OUTPUT_PIN + i] & next_st.enable[i]
                         & ~adc_channel_select[FIRST_OUTPUT_PIN + i];
      // flagged, not corrected: software owns these combinations
      next_st.conflict[i] = ~next_st.adsel[FIRST_OUTPUT_PIN + i]
                            & (~next_st.dir[FIRST_OUTPUT_PIN + i]
                               | (next_st.enable[i]
                                  & adc_channel_select[FIRST_OUTPUT_PIN + i]));
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      // blanket clear first; the port registers take their own reset values
      // below, and only the direction register and analog input flags are not zero
      st <= '0;
      st.adsel <= RESET_PORT_ANALOG_DIGITAL_SELECT;
      st.dir <= RESET_PORT_TWO_DIRECTION;
      st.data <= RESET_PORT_TWO_DATA;
      st.ana_in <= ~RESET_PORT_ANALOG_DIGITAL_SELECT;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  // the channels see the gate one cycle late, through st.gate; that is
  // the held reset, and it also drops any code left on the ladder,
  // so a channel never resumes with a stale value after power-up
  generate
    for (genvar g = 0; g < CHANNEL_COUNT; g++) begin : g_chan
      dac_channel #(
        .SETTLE(SETTLE)
      ) u_chan (
        .clk(clk),
        .reset(reset),
        .clear(~st.gate),
        .enable(st.enable[g]),
        .rt_mode(st.mode[g]),
        .value_write(st.value_write[g]),
        .trigger(rt_trigger[g]),
        .value(st.value[g]),
        .code(code[g]),
        .busy(code_busy[g]),
        .settled(code_settled[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign cpu_rdata = st.rdata;
  assign pins = st.pins;
  assign analog_drive = st.drive;
  assign analog_input_pin = st.ana_in;
  assign setting_conflict = st.conflict;
  // channel 1 sits in the upper ten bits of the code bus
  assign channel_code = {code[1], code[0]};
  assign channel_busy = code_busy;
  assign channel_settled = code_settled;

endmodule

// [test/dac_control_props.sv]
// port-level assertions for the converter control block
`timescale 1ns/1ns
module dac_control_props
  import dac_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire dac_req_t cpu_req,
  input wire logic [15:0] cpu_rdata,
  input wire logic [7:0] pin_in,
  input wire dac_pins_t pins,
  input wire logic [7:0] adc_channel_select,
  input wire logic [1:0] rt_trigger,
  input wire logic [1:0] analog_drive,
  input wire logic [7:0] analog_input_pin,
  input wire logic [1:0] setting_conflict,
  input wire logic [19:0] channel_code,
  input wire logic [1:0] channel_busy,
  input wire logic [1:0] channel_settled
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // helper: length of the current busy run of channel 0
  // ----------------------------------------------------------------
  logic [15:0] run0; // restarts extend the run, so only a floor is checked
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      run0 <= 16'h0;
    end else begin
      run0 <= channel_busy[0] ? run0 + 16'h1 : 16'h0;
    end
  end
  // ----------------------------------------------------------------
  // bus sequences
  // ----------------------------------------------------------------
  sequence gate_off_write;
    cpu_req.wr && cpu_req.addr == ADDR_PERIPHERAL_CLOCK_ENABLE_ONE && !cpu_req.wdata[7];
  endsequence
  sequence value_read;
    cpu_req.rd && cpu_req.addr[19:2] == ADDR_CHANNEL0_OUTPUT_VALUE[19:2] && !cpu_req.addr[0];
  endsequence
  sequence data_read;
    cpu_req.rd && cpu_req.addr == ADDR_PORT_TWO_DATA;
  endsequence
  chk_gate_clears: assert property (gate_off_write |-> ##[1:3]
    (channel_code == 20'h0 && channel_busy == 2'h0 && channel_settled == 2'h0))
    else $error("gate clear left channel state");
  chk_value_upper: assert property (value_read |=> cpu_rdata[15:10] == 6'h0)
    else $error("value read upper bits not zero");
  chk_port_analog: assert property (data_read |=> (cpu_rdata[7:0] & analog_input_pin) == 8'h0)
    else $error("analog input pin read nonzero");
  chk_rdata_idle: assert property (!cpu_req.rd |=> cpu_rdata == 16'h0)
    else $error("read data without read");
  chk_oe_analog: assert property ((pins.oe & analog_input_pin) == 8'h0)
    else $error("buffer on an analog input pin");
  chk_drive_unsel: assert property ((analog_drive &
    {$past(adc_channel_select[3]), $past(adc_channel_select[2])}) == 2'h0)
    else $error("analog drive on selected pin");
  chk_drive_conflict: assert property ((analog_drive & setting_conflict) == 2'h0)
    else $error("drive during prohibited setting");
  chk_settle_len: assert property ($rose(channel_settled[0]) |-> run0 >= SETTLE)
    else $error("settled too early");
  chk_busy_settled: assert property ((channel_busy & channel_settled) == 2'h0)
    else $error("busy and settled together");
endmodule
bind dac_control dac_control_props #(.SETTLE(SETTLE)) u_props (.clk(clk), .reset(reset),
  .cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .pin_in(pin_in), .pins(pins),
  .adc_channel_select(adc_channel_select), .rt_trigger(rt_trigger),
  .analog_drive(analog_drive), .analog_input_pin(analog_input_pin),
  .setting_conflict(setting_conflict), .channel_code(channel_code),
  .channel_busy(channel_busy), .channel_settled(channel_settled));

// [test/tb_dac_control.sv]
// self-checking bench for the converter control block
`timescale 1ns/1ns
module tb_dac_control;
  import dac_pkg::*;
  localparam int ST = 4; // short settling keeps the run brief
  logic clk, reset;
  dac_req_t req;
  logic [15:0] rdata;
  logic [7:0] pin_in, adc, ai;
  logic [1:0] trig, drive, confl, busy, setl;
  logic [19:0] code;
  dac_pins_t pins;
  int n_mismatch = 0;
  int checked = 0;
  dac_control #(.SETTLE(ST)) u_dut (.clk(clk), .reset(reset), .cpu_req(req),
    .cpu_rdata(rdata), .pin_in(pin_in), .pins(pins), .adc_channel_select(adc),
    .rt_trigger(trig), .analog_drive(drive), .analog_input_pin(ai),
    .setting_conflict(confl), .channel_code(code), .channel_busy(busy),
    .channel_settled(setl));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input string nm, input logic [19:0] e, input logic [19:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one write, then an idle cycle so a strobe never toggles twice in a step
  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    cyc(1);
    req.wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [19:0] a, input logic [15:0] e);
    logic [15:0] g;
    req.addr = a;
    req.rd = 1'b1;
    cyc(1);
    g = rdata;
    req.rd = 1'b0;
    cyc(1);
    check($sformatf("reg %h", a), 20'(e), 20'(g));
  endtask
  task automatic wait_set(input int i);
    for (int k = 0; k < 30 && setl[i] !== 1'b1; k++) cyc(1);
    check("settled", 20'h1, 20'(setl[i]));
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #100000;
    n_mismatch++;
    close_out;
  end
  initial begin
    reset = 1'b1;
    req = '0;
    pin_in = 8'hFF;
    adc = 8'h00;
    trig = 2'h0;
    cyc(8);
    reset = 1'b0;
    rd(ADDR_PORT_TWO_DIRECTION, 16'h00FF);
    rd(ADDR_PORT_ANALOG_DIGITAL_SELECT, 16'h0000);
    check("ain", 20'hFF, 20'(ai));
    // gate still off: converter writes dropped, port writes land
    wr(ADDR_CONVERTER_MODE_CONTROL, 16'h0030);
    wr(ADDR_CHANNEL0_OUTPUT_VALUE, 16'h0155);
    rd(ADDR_CONVERTER_MODE_CONTROL, 16'h0000);
    rd(ADDR_CHANNEL0_OUTPUT_VALUE, 16'h0000);
    wr(ADDR_PORT_ANALOG_DIGITAL_SELECT, 16'h0083);
    wr(ADDR_PORT_TWO_DIRECTION, 16'h00FC);
    wr(ADDR_PORT_TWO_DATA, 16'h00A5);
    check("oe", 20'h03, 20'(pins.oe));
    check("out", 20'hA5, 20'(pins.out));
    rd(ADDR_PORT_TWO_DATA, 16'h0081);
    wr(ADDR_PERIPHERAL_CLOCK_ENABLE_ONE, 16'h0080);
    rd(ADDR_PERIPHERAL_CLOCK_ENABLE_ONE, 16'h0080);
    wr(ADDR_CHANNEL1_OUTPUT_VALUE, 16'hFFFF);
    rd(ADDR_CHANNEL1_OUTPUT_VALUE, 16'h03FF);
    rd(20'hFFF00, 16'h0000);
    wr(ADDR_CHANNEL0_OUTPUT_VALUE, 16'h0155);
    wr(ADDR_CONVERTER_MODE_CONTROL, 16'h0010);
    cyc(1);
    check("busy0", 20'h1, 20'(busy[0]));
    check("code0", 20'h155, 20'(code[9:0]));
    // busy for exactly ST cycles, settled on the edge it falls
    cyc(ST - 2);
    check("busy0", 20'h1, 20'(busy[0]));
    cyc(1);
    check("busy0", 20'h0, 20'(busy[0]));
    check("set0", 20'h1, 20'(setl[0]));
    wait_set(0);
    check("drive", 20'h1, 20'(drive));
    check("ain", 20'h78, 20'(ai));
    // rewrite inside the settling interval restarts it
    wr(ADDR_CHANNEL0_OUTPUT_VALUE, 16'h02AA);
    wr(ADDR_CHANNEL0_OUTPUT_VALUE, 16'h03C3);
    cyc(1);
    check("code0", 20'h3C3, 20'(code[9:0]));
    check("set0", 20'h0, 20'(setl[0]));
    wait_set(0);
    adc = 8'h0C;
    cyc(2);
    check("drive", 20'h0, 20'(drive));
    check("confl", 20'h1, 20'(confl));
    check("ain", 20'h78, 20'(ai));
    adc = 8'h00;
    wr(ADDR_PORT_TWO_DIRECTION, 16'h00F8);
    check("confl", 20'h1, 20'(confl));
    check("drive", 20'h0, 20'(drive));
    wr(ADDR_PORT_TWO_DIRECTION, 16'h00FC);
    // channel 1 in real-time mode: enabling and then the trigger start it, a value write does not
    wr(ADDR_CHANNEL1_OUTPUT_VALUE, 16'h00AB);
    wr(ADDR_CONVERTER_MODE_CONTROL, 16'h0032);
    wait_set(1);
    check("code1", 20'h0AB, 20'(code[19:10]));
    wr(ADDR_CHANNEL1_OUTPUT_VALUE, 16'h01CD);
    cyc(2);
    check("busy1", 20'h0, 20'(busy[1]));
    trig = 2'h2;
    cyc(1);
    trig = 2'h0;
    cyc(1);
    check("busy1", 20'h1, 20'(busy[1]));
    check("code1", 20'h1CD, 20'(code[19:10]));
    rd(ADDR_CONVERTER_MODE_CONTROL, 16'h0032);
    wr(ADDR_PERIPHERAL_CLOCK_ENABLE_ONE, 16'h0000);
    cyc(1);
    check("codes", 20'h0, code);
    rd(ADDR_CHANNEL1_OUTPUT_VALUE, 16'h0000);
    wr(ADDR_PERIPHERAL_CLOCK_ENABLE_ONE, 16'h0080);
    rd(ADDR_CONVERTER_MODE_CONTROL, 16'h0000);
    wr(ADDR_CHANNEL0_OUTPUT_VALUE, 16'h0000);
    rd(ADDR_CHANNEL0_OUTPUT_VALUE, 16'h0000);
    rd(ADDR_PORT_TWO_DIRECTION, 16'h00FC);
    close_out;
  end
endmodule
